// *** hdl/meter_cmd_core.sv ***
// Purpose: command executor for status and function commands of a meter
// Assumes: commands arrive as register writes; status bits 0..5 come from outside
// Notes: one command executes in the cycle after its write is committed
`timescale 1ns/100ps
`include "meter_cmd_defines.svh"

// What this block does
// R1: enable command loads register from 0..255
// R2: bit 6 of enable value is dropped
// R3: out-of-range enable value raises execution error
// R4: enable query returns register, bit 6 zero
// R5: status query returns byte with summary bit 6
// R6: replies other than function queries are integers mirroring register bits
// R7: trigger command starts one measurement
// R8: self test answers zero; wait does nothing
// R9: primary query returns primary function code
// R10: secondary query returns code or raises error
// R11: wire count selectable only in resistance
// R12: AC plus DC primary refuses secondary selection
// R13: secondary clear removes secondary measurement
// R14: six functions selectable on both displays
// R15: AC+DC, continuity, diode are primary only
// R16: summary bit is OR of enabled status bits
// R17: service request set, shown on poll, cleared
module meter_cmd_core
    import meter_cmd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] status_src,
    input wire logic front_service_req,
    input wire logic serial_poll,
    output logic [7:0] poll_byte,
    output logic poll_valid,
    output logic meas_trigger,
    output logic irq
);
    wire logic wr_pulse;
    wire logic [7:0] wr_addr;
    wire logic [31:0] wr_data;
    wire logic [3:0] wr_strb;
    wire logic [7:0] rd_addr;
    logic [31:0] rd_data;
    wire logic [`IRQ_N-1:0] irq_stat;
    wire logic [`IRQ_N-1:0] irq_mask;

    logic cmd_go_r;
    cmd_code_t cmd_r;
    logic [31:0] arg_r;
    logic [7:0] sre_r;
    func_code_t prim_func_r;
    func_code_t sec_func_r;
    logic four_wire_select_r;
    logic [7:0] reply_val_r;
    reply_kind_t reply_kind_r;
    logic rqs_r;
    logic mss_q_r;
    logic [7:0] poll_byte_r;
    logic poll_valid_r;
    logic trig_r;

    // register write decode
    wire logic wsel_cmd = wr_addr == `REG_CMD;
    wire logic wsel_arg = wr_addr == `REG_ARG;
    wire logic wsel_stat = wr_addr == `REG_IRQ_STAT;
    wire logic wsel_mask = wr_addr == `REG_IRQ_MASK;
    wire logic wr_ok = wsel_cmd | wsel_arg | wsel_stat | wsel_mask;
    wire logic cmd_wr = wr_pulse & wsel_cmd & wr_strb[0];

    // register read decode
    wire logic rsel_cmd = rd_addr == `REG_CMD;
    wire logic rsel_arg = rd_addr == `REG_ARG;
    wire logic rsel_reply = rd_addr == `REG_REPLY;
    wire logic rsel_state = rd_addr == `REG_STATE;
    wire logic rsel_stat = rd_addr == `REG_IRQ_STAT;
    wire logic rsel_mask = rd_addr == `REG_IRQ_MASK;
    wire logic rd_ok = rsel_cmd | rsel_arg | rsel_reply | rsel_state | rsel_stat | rsel_mask;

    // command decode
    wire func_code_t cmd_fn = cmd_r[3:0];
    wire logic is_pri_sel = (cmd_r >= `CMD_PRI_FIRST) && (cmd_r <= `CMD_PRI_LAST); // R14 R15
    // only six functions have a secondary form
    wire logic sec_fn_legal = (cmd_fn == `FN_AC_CUR) || (cmd_fn == `FN_DC_CUR)
        || (cmd_fn == `FN_FREQUENCY) || (cmd_fn == `FN_RES)
        || (cmd_fn == `FN_AC_VOLT) || (cmd_fn == `FN_DC_VOLT); // R14 R15
    wire logic is_sec_sel = cmd_r[`SEC_FLAG_BIT] & sec_fn_legal;
    wire logic is_sec_clr = cmd_r == `CMD_SEC_CLEAR;
    wire logic is_sre_set = cmd_r == `CMD_SRE_SET;
    wire logic is_sre_q = cmd_r == `CMD_SRE_QUERY;
    wire logic is_stb_q = cmd_r == `CMD_STB_QUERY;
    wire logic is_trg = cmd_r == `CMD_TRIGGER;
    wire logic is_tst = cmd_r == `CMD_SELF_TEST;
    wire logic is_wait = cmd_r == `CMD_WAIT;
    wire logic is_pri_q = cmd_r == `CMD_PRI_QUERY;
    wire logic is_sec_q = cmd_r == `CMD_SEC_QUERY;
    wire logic is_wire_two = cmd_r == `CMD_WIRE_TWO;
    wire logic is_wire_four = cmd_r == `CMD_WIRE_FOUR;
    wire logic is_wire = is_wire_two | is_wire_four;
    wire logic known = is_pri_sel | is_sec_sel | is_sec_clr | is_sre_set | is_sre_q
        | is_stb_q | is_trg | is_tst | is_wait | is_pri_q | is_sec_q | is_wire;

    wire logic pri_acdc = (prim_func_r == `FN_ACDC_CUR) || (prim_func_r == `FN_ACDC_VOLT);
    wire logic new_acdc = (cmd_fn == `FN_ACDC_CUR) || (cmd_fn == `FN_ACDC_VOLT);
    wire logic arg_ok = arg_r[31:8] == `ARG_HIGH_ZERO; // R3
    wire logic sec_idle = sec_func_r == `FN_NONE;

    // any refusal leaves every command-driven register untouched and only raises the execution error flag
    wire logic refuse = ~known
        | (is_sre_set & ~arg_ok) // R3
        | (is_sec_sel & pri_acdc) // R12
        | (is_sec_q & sec_idle) // R10
        | (is_wire & (prim_func_r != `FN_RES)); // R11
    wire logic exec_err = cmd_go_r & refuse;
    wire logic exec_ok = cmd_go_r & ~refuse;

    // status byte: bit 7 unused, bit 6 summary
    wire logic mss_w = |(status_src & sre_r[5:0]); // R16
    wire logic [7:0] stb_w = {1'b0, mss_w, status_src}; // R5

    // next state of the command-driven registers
    wire logic [7:0] sre_nxt = (exec_ok & is_sre_set) ? (arg_r[7:0] & `SRE_UNUSED_MASK) : sre_r; // R1 R2
    wire func_code_t prim_nxt = (exec_ok & is_pri_sel) ? cmd_fn : prim_func_r;
    // AC plus DC cannot coexist with a secondary reading, so drop it
    wire logic sec_drop = is_sec_clr | (is_pri_sel & new_acdc); // R13
    wire func_code_t sec_nxt = ~exec_ok ? sec_func_r
        : is_sec_sel ? cmd_fn
        : sec_drop ? `FN_NONE : sec_func_r;
    wire logic four_wire_select_nxt = (exec_ok & is_wire) ? is_wire_four : four_wire_select_r; // R11

    // replies are plain binary; function query replies are marked as mnemonics, the others as integers
    wire logic reply_ev = exec_ok & (is_sre_q | is_stb_q | is_tst | is_pri_q | is_sec_q);
    wire logic reply_mnem = is_pri_q | is_sec_q;
    wire logic [7:0] reply_nxt = is_sre_q ? (sre_r & `SRE_UNUSED_MASK) // R4 R6
        : is_stb_q ? stb_w // R5
        : is_pri_q ? {4'h0, prim_func_r} // R9
        : is_sec_q ? {4'h0, sec_func_r} // R10
        : `SELF_TEST_RESULT; // R8

    // a new request raises the flag; held summary does not re-arm it after a poll
    wire logic rqs_set = front_service_req | (mss_w & ~mss_q_r); // R17
    wire logic rqs_nxt = rqs_set | (rqs_r & ~serial_poll); // R17

    wire logic [`IRQ_N-1:0] ev_set = {exec_ok & is_trg, reply_ev, exec_err};
    wire logic [31:0] state_w = {stb_w, sre_r, 5'h00, rqs_r, mss_w, four_wire_select_r, sec_func_r, prim_func_r};

    logic [31:0] arg_nxt;
    genvar gb;
    for (gb = 0; gb < 4; gb++) begin : g_arg_lane
        assign arg_nxt[gb*8 +: 8] = (wr_pulse & wsel_arg & wr_strb[gb]) ? wr_data[gb*8 +: 8] : arg_r[gb*8 +: 8];
    end

    assign rd_data = rsel_cmd ? {27'h0000000, cmd_r}
        : rsel_arg ? arg_r
        : rsel_reply ? {23'h000000, reply_kind_r, reply_val_r}
        : rsel_state ? state_w
        : rsel_stat ? {29'h00000000, irq_stat}
        : rsel_mask ? {29'h00000000, irq_mask}
        : 32'h00000000;

    assign poll_byte = poll_byte_r;
    assign poll_valid = poll_valid_r;
    assign meas_trigger = trig_r;

    axil_port u_port (
        .sys_clk(sys_clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    event_flags #(.N(`IRQ_N)) u_flags (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_ev(ev_set),
        .clr_we(wr_pulse & wsel_stat & wr_strb[0]),
        .clr_bits(wr_data[`IRQ_N-1:0]),
        .mask_we(wr_pulse & wsel_mask & wr_strb[0]),
        .mask_bits(wr_data[`IRQ_N-1:0]),
        .status_r(irq_stat),
        .mask_r(irq_mask),
        .irq_r(irq)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_go_r <= 1'b0;
            cmd_r <= 5'h00;
            arg_r <= 32'h00000000;
        end else begin
            cmd_go_r <= cmd_wr;
            if (cmd_wr) begin
                cmd_r <= wr_data[4:0];
            end
            arg_r <= arg_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sre_r <= 8'h00;
            prim_func_r <= `PRI_FUNC_RST;
            sec_func_r <= `FN_NONE;
            four_wire_select_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            sre_r <= sre_nxt;
            prim_func_r <= prim_nxt;
            sec_func_r <= sec_nxt;
            four_wire_select_r <= four_wire_select_nxt;
            trig_r <= exec_ok & is_trg; // R7
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reply_val_r <= 8'h00;
            reply_kind_r <= REPLY_INTEGER;
        end else if (reply_ev) begin
            reply_val_r <= reply_nxt;
            reply_kind_r <= reply_mnem ? REPLY_MNEMONIC : REPLY_INTEGER;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rqs_r <= 1'b0;
            mss_q_r <= 1'b0;
            poll_byte_r <= 8'h00;
            poll_valid_r <= 1'b0;
        end else begin
            rqs_r <= rqs_nxt;
            mss_q_r <= mss_w;
            poll_valid_r <= serial_poll;
            if (serial_poll) begin
                poll_byte_r <= {1'b0, rqs_r, status_src}; // R17
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_sre_load_value: assert property ( // R1
        exec_ok && is_sre_set |=> sre_r == ($past(arg_r[7:0]) & `SRE_UNUSED_MASK))
        else $error("enable register not loaded from argument");
    a_sre_unused_bit: assert property ( // R2
        cmd_go_r && is_sre_set && arg_r[6] |=> !sre_r[6])
        else $error("unused enable bit was stored");
    a_sre_range_err: assert property ( // R3
        cmd_go_r && is_sre_set && !arg_ok |=> $stable(sre_r) && irq_stat[`IRQ_EXEC_ERR])
        else $error("out-of-range enable value not refused");
    a_sre_query_bit6: assert property ( // R4
        cmd_go_r && is_sre_q |=> !reply_val_r[6] && reply_kind_r == REPLY_INTEGER)
        else $error("enable query reply wrong");
    a_stb_summary: assert property ( // R5 R16
        cmd_go_r && is_stb_q |=> reply_val_r[6] == |($past(status_src) & $past(sre_r[5:0]))
            && reply_val_r[5:0] == $past(status_src))
        else $error("status byte reply wrong");
    a_trigger_once: assert property ( // R7
        exec_ok && is_trg |=> meas_trigger ##1 !meas_trigger)
        else $error("trigger not a single pulse");
    a_self_test_zero: assert property ( // R8
        cmd_go_r && is_tst |=> reply_val_r == `SELF_TEST_RESULT)
        else $error("self test reply not zero");
    a_pri_query_code: assert property ( // R9
        cmd_go_r && is_pri_q |=> reply_val_r[3:0] == $past(prim_func_r) && reply_kind_r == REPLY_MNEMONIC)
        else $error("primary query reply wrong");
    a_sec_query_err: assert property ( // R10
        cmd_go_r && is_sec_q && sec_idle |=> irq_stat[`IRQ_EXEC_ERR] && $stable(reply_val_r))
        else $error("idle secondary query not refused");
    a_wire_res_only: assert property ( // R11
        $changed(four_wire_select_r) |-> $past(prim_func_r) == `FN_RES)
        else $error("wire mode changed outside resistance");
    a_acdc_refuse_sec: assert property ( // R12
        cmd_go_r && is_sec_sel && pri_acdc |=> $stable(sec_func_r) && irq_stat[`IRQ_EXEC_ERR])
        else $error("secondary selected under AC plus DC");
    a_sec_clear_none: assert property ( // R13
        cmd_go_r && is_sec_clr |=> sec_func_r == `FN_NONE)
        else $error("secondary not cleared");
    a_rqs_poll_clear: assert property ( // R17
        serial_poll && !rqs_set |=> !rqs_r && poll_valid && poll_byte[6] == $past(rqs_r))
        else $error("poll did not report and clear request");

    c_sre_loaded: cover property (exec_ok && is_sre_set ##1 sre_r != 8'h00);
    c_trigger: cover property (meas_trigger);
    c_acdc_refused: cover property (cmd_go_r && is_sec_sel && pri_acdc);
    c_poll_rqs: cover property (serial_poll && rqs_r);
endmodule

// *** hdl/meter_cmd_defines.svh ***
// Purpose: constants of the meter command block
// Assumes: included by bare name; addresses are byte offsets
// Notes: function codes double as reply mnemonics
`ifndef METER_CMD_DEFINES_SVH
`define METER_CMD_DEFINES_SVH

`define REG_CMD 8'h00
`define REG_ARG 8'h04
`define REG_REPLY 8'h08
`define REG_STATE 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define FN_NONE 4'h0
`define FN_AC_CUR 4'h1
`define FN_ACDC_CUR 4'h2
`define FN_DC_CUR 4'h3
`define FN_CONT 4'h4
`define FN_DIODE 4'h5
`define FN_FREQUENCY 4'h6
`define FN_RES 4'h7
`define FN_AC_VOLT 4'h8
`define FN_ACDC_VOLT 4'h9
`define FN_DC_VOLT 4'hA
`define PRI_FUNC_RST `FN_DC_VOLT

`define CMD_PRI_FIRST 5'h01
`define CMD_PRI_LAST 5'h0A
`define CMD_SRE_SET 5'h0B
`define CMD_SRE_QUERY 5'h0C
`define CMD_STB_QUERY 5'h0D
`define CMD_TRIGGER 5'h0E
`define CMD_SELF_TEST 5'h0F
`define CMD_SEC_CLEAR 5'h10
`define CMD_WAIT 5'h1B
`define CMD_PRI_QUERY 5'h1C
`define CMD_SEC_QUERY 5'h1D
`define CMD_WIRE_TWO 5'h1E
`define CMD_WIRE_FOUR 5'h1F
`define SEC_FLAG_BIT 4

`define SRE_UNUSED_MASK 8'hBF
`define ARG_HIGH_ZERO 24'h000000
`define SELF_TEST_RESULT 8'h00

`define IRQ_N 3
`define IRQ_EXEC_ERR 0
`define IRQ_REPLY 1
`define IRQ_TRIGGER 2

`endif

// *** hdl/meter_cmd_pkg.sv ***
// Purpose: shared types of the meter command block
// Assumes: nothing
// Notes: codes themselves live in the defines header
package meter_cmd_pkg;
    typedef logic [3:0] func_code_t;
    typedef logic [4:0] cmd_code_t;
    typedef enum logic {REPLY_INTEGER, REPLY_MNEMONIC} reply_kind_t;
endpackage

// *** hdl/axil_port.sv ***
// Purpose: AXI4-Lite slave handshake, one write and one read at a time
// Assumes: core decodes addresses and supplies read data
// Notes: read data is sampled when the address is taken
`timescale 1ns/100ps
`include "meter_cmd_defines.svh"

module axil_port (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_pulse,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;

    wire logic aw_take = s_axi_awvalid & awready_r;
    wire logic w_take = s_axi_wvalid & wready_r;
    wire logic ar_take = s_axi_arvalid & arready_r;

    // both halves held and no response pending: commit once
    assign wr_pulse = ~awready_r & ~wready_r & ~bvalid_r;
    assign wr_addr = waddr_r;
    assign wr_data = wdata_r;
    assign wr_strb = wstrb_r;
    assign rd_addr = s_axi_araddr;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            waddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (aw_take) begin
                awready_r <= 1'b0;
                waddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_pulse) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_OKAY;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_ok ? rd_data : 32'h00000000;
            rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end
endmodule

// *** hdl/event_flags.sv ***
// Purpose: sticky event bits, mask and one level interrupt
// Assumes: set_ev are one-cycle pulses
// Notes: a set in the clearing cycle survives the clear
`timescale 1ns/100ps

module event_flags #(
    parameter int N = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N-1:0] set_ev,
    input wire logic clr_we,
    input wire logic [N-1:0] clr_bits,
    input wire logic mask_we,
    input wire logic [N-1:0] mask_bits,
    output logic [N-1:0] status_r,
    output logic [N-1:0] mask_r,
    output logic irq_r
);
    wire logic [N-1:0] clr_eff = clr_we ? clr_bits : {N{1'b0}};
    wire logic [N-1:0] status_nxt = set_ev | (status_r & ~clr_eff);
    wire logic [N-1:0] mask_nxt = mask_we ? mask_bits : mask_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_r <= {N{1'b0}};
            mask_r <= {N{1'b0}};
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= |(status_nxt & mask_nxt);
        end
    end
endmodule

// *** testbench/host_model.sv ***
// Purpose: host side of the register bus, one write or one read at a time
// Assumes: tasks are entered just after a rising edge
// Notes: handshakes judged at the falling edge, acted on at the next rise
`timescale 1ns/100ps
module host_model (
    input wire logic sys_clk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end
    // released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ap, wp, bp, ah, wh, bh;
        {ap, wp, bp} = 3'h7;
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        while (ap | wp | bp) begin
            @(negedge sys_clk);
            ah = ap & awready;
            wh = wp & wready;
            bh = bp & bvalid;
            r = bresp;
            @(posedge sys_clk);
            if (ah) {awvalid, awaddr} <= {1'b0, ~a};
            if (wh) {wvalid, wdata} <= {1'b0, ~d};
            if (bh) bready <= 1'b0;
            {ap, wp, bp} = {ap & !ah, wp & !wh, bp & !bh};
        end
        // idle edge: a following call never re-raises bready in the step that lowered it
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ap, rp, ah, rh;
        {ap, rp} = 2'h3;
        {araddr, arvalid, rready} <= {a, 2'h3};
        while (ap | rp) begin
            @(negedge sys_clk);
            ah = ap & arready;
            rh = rp & rvalid;
            {d, r} = {rdata, rresp};
            @(posedge sys_clk);
            if (ah) {arvalid, araddr} <= {1'b0, ~a};
            if (rh) rready <= 1'b0;
            {ap, rp} = {ap & !ah, rp & !rh};
        end
        @(posedge sys_clk);
    endtask
endmodule

// *** testbench/tb.sv ***
// Purpose: self-checking bench of the meter command block
// Assumes: host_model speaks the register bus
// Notes: each command sent through cmd is followed by a read and clear of the event bits
`timescale 1ns/100ps
`include "meter_cmd_defines.svh"
module tb;
    logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic serial_poll, front_service_req, poll_valid, meas_trigger, irq;
    logic [7:0] awaddr, araddr, poll_byte;
    logic [31:0] wdata, rdata, got, s;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [5:0] status_src;
    int mismatches, total_checks, cycles, trig_cnt;
    meter_cmd_core dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .status_src(status_src),
        .front_service_req(front_service_req), .serial_poll(serial_poll), .poll_byte(poll_byte),
        .poll_valid(poll_valid), .meas_trigger(meas_trigger), .irq(irq));
    host_model host (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // falling edge keeps the count clear of the flop update race
    always @(negedge sys_clk) begin
        if (meas_trigger === 1'b1) trig_cnt++;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            wrap_up;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input logic [4:0] c, input logic e);
        host.wr(`REG_CMD, {27'h0000000, c}, resp);
        @(posedge sys_clk);
        host.rd(`REG_IRQ_STAT, got, resp);
        chk("exec_error", {31'h0, e}, {31'h0, got[`IRQ_EXEC_ERR]});
        host.wr(`REG_IRQ_STAT, 32'h00000007, resp);
    endtask
    task automatic rep(input logic [31:0] e);
        host.rd(`REG_REPLY, got, resp);
        chk("reply", e, got);
    endtask
    task automatic poll(input logic [7:0] e);
        serial_poll <= 1'b1;
        @(posedge sys_clk);
        serial_poll <= 1'b0;
        @(negedge sys_clk);
        chk("poll", {23'h0, 1'b1, e}, {23'h0, poll_valid, poll_byte});
        @(posedge sys_clk);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge sys_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge sys_clk);
    endtask
    task automatic t_sre;
        host.wr(`REG_ARG, 32'h000000FF, resp);
        cmd(`CMD_SRE_SET, 1'b0);
        cmd(`CMD_SRE_QUERY, 1'b0);
        rep(32'h000000BF);
        host.wr(`REG_ARG, 32'h00000100, resp);
        cmd(`CMD_SRE_SET, 1'b1);
        host.wr(`REG_ARG, 32'hFFFFFFFF, resp);
        cmd(`CMD_SRE_SET, 1'b1);
        cmd(`CMD_SRE_QUERY, 1'b0);
        rep(32'h000000BF);
    endtask
    task automatic t_stb;
        status_src <= 6'h01;
        cmd(`CMD_STB_QUERY, 1'b0);
        rep(32'h00000041);
        poll(8'h41);
        poll(8'h01);
        host.wr(`REG_ARG, 32'h00000002, resp);
        cmd(`CMD_SRE_SET, 1'b0);
        cmd(`CMD_STB_QUERY, 1'b0);
        rep(32'h00000001);
        front_service_req <= 1'b1;
        @(posedge sys_clk);
        front_service_req <= 1'b0;
        poll(8'h41);
    endtask
    task automatic t_trig;
        int n;
        n = trig_cnt;
        cmd(`CMD_TRIGGER, 1'b0);
        chk("trigger_count", n + 1, trig_cnt);
        cmd(`CMD_SELF_TEST, 1'b0);
        rep(32'h00000000);
        host.rd(`REG_STATE, s, resp);
        cmd(`CMD_WAIT, 1'b0);
        host.rd(`REG_STATE, got, resp);
        chk("state_after_wait", s, got);
    endtask
    task automatic t_func;
        logic ok;
        for (int c = 1; c <= 10; c++) begin
            cmd(5'(c), 1'b0);
            cmd(`CMD_PRI_QUERY, 1'b0);
            rep(32'h00000100 | 32'(c));
        end
        for (int c = 1; c <= 10; c++) begin
            ok = c inside {1, 3, 6, 7, 8, 10};
            cmd(5'h10 | 5'(c), !ok);
            if (ok) begin
                cmd(`CMD_SEC_QUERY, 1'b0);
                rep(32'h00000100 | 32'(c));
            end
        end
        cmd(`CMD_SEC_CLEAR, 1'b0);
        cmd(`CMD_SEC_QUERY, 1'b1);
        cmd(`CMD_WIRE_FOUR, 1'b1);
        cmd(5'h07, 1'b0);
        cmd(`CMD_WIRE_FOUR, 1'b0);
        host.rd(`REG_STATE, got, resp);
        chk("four_wire_select", 32'h00000001, {31'h0, got[8]});
        cmd(`CMD_WIRE_TWO, 1'b0);
        host.rd(`REG_STATE, got, resp);
        chk("four_wire_select", 32'h00000000, {31'h0, got[8]});
        cmd(5'h02, 1'b0);
        cmd(5'h16, 1'b1);
        cmd(5'h09, 1'b0);
        cmd(5'h11, 1'b1);
    endtask
    task automatic t_irq;
        host.wr(`REG_CMD, 32'h00000011, resp);
        chk_irq(1'b0);
        host.wr(`REG_IRQ_MASK, 32'h00000001, resp);
        chk_irq(1'b1);
        host.wr(`REG_IRQ_STAT, 32'h00000001, resp);
        chk_irq(1'b0);
        host.rd(8'h18, got, resp);
        chk("unmapped", 32'h00000002, {got[29:0], resp});
        host.wr(`REG_REPLY, 32'h00000000, resp);
        chk("read_only", 32'h00000002, {30'h0, resp});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        {status_src, front_service_req, serial_poll} = '0;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_sre;
        t_stb;
        t_trig;
        t_func;
        t_irq;
        wrap_up;
    end
endmodule
